// file: rtl/config_reg_a_defs.vh
// constants for configuration register a and its datapath helpers
`ifndef CONFIG_REG_A_DEFS_VH
`define CONFIG_REG_A_DEFS_VH
// register location and reset image
`define CFG_A_OFFSET 7'h5A
`define CFG_A_RESET 16'h1170
`define CFG_A_RESERVED_MASK 16'h0000
// field positions
`define FLD_FULL_COMPLIANCE 0
`define FLD_DOUBLE_BUFFER 1
`define FLD_GAIN_LO 2
`define FLD_GAIN_HI 3
`define FLD_AMP_RESET 4
`define FLD_ZERO_DETECT 5
`define FLD_TRUTH_TABLE 6
`define FLD_PLL_MULT 7
`define FLD_PLL_ROUTE 8
`define FLD_MCLK_RATE 9
`define FLD_INPUT_SEL 10
`define FLD_SPDIF_MODE 11
`define FLD_AA_THR_LO 12
`define FLD_AA_THR_HI 13
`define FLD_RATIO_DEBUG 14
`define FLD_RESAMPLER_BYPASS 15
// anti-alias band edges in Hz and derived input periods in ref clock cycles
`define REF_CLK_HZ 40000000
`define AA_BAND1_LO_HZ 58875
`define AA_BAND1_HI_HZ 61125
`define AA_BAND2_LO_HZ 78973
`define AA_BAND2_HI_HZ 81000
`define AA_BAND1_ON_CYC (`REF_CLK_HZ / `AA_BAND1_HI_HZ)
`define AA_BAND1_OFF_CYC (`REF_CLK_HZ / `AA_BAND1_LO_HZ)
`define AA_BAND2_ON_CYC (`REF_CLK_HZ / `AA_BAND2_HI_HZ)
`define AA_BAND2_OFF_CYC (`REF_CLK_HZ / `AA_BAND2_LO_HZ)
// zero detect run length in samples
`define ZERO_RUN_SAMPLES 12'h800
// the nine limiter constants
`define LIM_ATTACK_THR 24'h7A0000
`define LIM_RELEASE_THR 24'h5A0000
`define LIM_ATTACK_STEP 16'h0040
`define LIM_ATTACK_EVERY 8'h04
`define LIM_RELEASE_STEP 16'h0008
`define LIM_RELEASE_EVERY 8'h40
`define LIM_HOLD_SAMPLES 16'h12C0
`define LIM_UNITY 16'h8000
`define LIM_FLOOR 16'h1000
`endif

// file: rtl/output_limiter.v
// output gain stage with clipping and gain compression
`timescale 1ns/10ps
`default_nettype none
`include "config_reg_a_defs.vh"
module output_limiter #(
  parameter W = 24
) (
  input wire clk_in,
  input wire reset_in,
  input wire [1:0] gain_sel_in,
  input wire [W-1:0] sample_in,
  input wire valid_in,
  output reg [W-1:0] sample_out,
  output reg valid_out
);
  reg signed [W+1:0] gained;
  reg [15:0] gain_q;
  reg [15:0] hold_cnt;
  reg [7:0] atk_cnt;
  reg [7:0] rel_cnt;
  wire signed [W+1:0] x = {{2{sample_in[W-1]}}, sample_in};
  wire compress = gain_sel_in[0];
  wire signed [W+18:0] prod = gained * $signed({1'b0, gain_q});
  wire signed [W+3:0] scaled = prod[W+18:15];
  wire [W+3:0] mag = scaled[W+3] ? -scaled : scaled;
  wire over = scaled > $signed({5'h00, {(W-1){1'b1}}});
  wire under = scaled < $signed({5'h1F, {(W-1){1'b0}}});
  // gain select: 1x, 2x or 3x
  always @* begin
    case (gain_sel_in)
      2'b00: gained = x;
      2'b01, 2'b10: gained = x <<< 1;
      default: gained = x + (x <<< 1);
    endcase
  end
  // clip, attack on loud samples, release after a quiet hold
  always @(posedge clk_in) begin
    if (reset_in) begin
      gain_q <= `LIM_UNITY;
      hold_cnt <= 16'h0000;
      atk_cnt <= 8'h00;
      rel_cnt <= 8'h00;
      sample_out <= {W{1'b0}};
      valid_out <= 1'b0;
    end else begin
      valid_out <= valid_in;
      if (valid_in) begin
        if (over) sample_out <= {1'b0, {(W-1){1'b1}}};
        else if (under) sample_out <= {1'b1, {(W-1){1'b0}}};
        else sample_out <= scaled[W-1:0];
        if (!compress) begin
          gain_q <= `LIM_UNITY;
          hold_cnt <= 16'h0000;
        end else if (mag > {4'h0, `LIM_ATTACK_THR}) begin
          hold_cnt <= 16'h0000;
          rel_cnt <= 8'h00;
          atk_cnt <= (atk_cnt == `LIM_ATTACK_EVERY - 8'h01) ? 8'h00 : atk_cnt + 8'h01;
          if (atk_cnt == 8'h00)
            gain_q <= (gain_q > `LIM_FLOOR + `LIM_ATTACK_STEP) ?
              gain_q - `LIM_ATTACK_STEP : `LIM_FLOOR;
        end else if (mag < {4'h0, `LIM_RELEASE_THR}) begin
          atk_cnt <= 8'h00;
          if (hold_cnt < `LIM_HOLD_SAMPLES) hold_cnt <= hold_cnt + 16'h0001;
          else begin
            rel_cnt <= (rel_cnt == `LIM_RELEASE_EVERY - 8'h01) ? 8'h00 : rel_cnt + 8'h01;
            if (rel_cnt == 8'h00)
              gain_q <= (gain_q < `LIM_UNITY - `LIM_RELEASE_STEP) ?
                gain_q + `LIM_RELEASE_STEP : `LIM_UNITY;
          end
        end else begin
          hold_cnt <= 16'h0000;
        end
      end
    end
  end
endmodule // output_limiter
`default_nettype wire

// file: rtl/input_sample_path.v
// input source selection, double buffering and resampler bypass
`timescale 1ns/10ps
`default_nettype none
module input_sample_path #(
  parameter W = 24
) (
  input wire clk_in,
  input wire reset_in,
  input wire source_sel_in,
  input wire double_buf_en_in,
  input wire bypass_in,
  input wire [W-1:0] serial_sample_in,
  input wire serial_valid_in,
  input wire [W-1:0] spdif_sample_in,
  input wire spdif_valid_in,
  input wire [W-1:0] resampled_in,
  input wire resampled_valid_in,
  input wire frame_tick_in,
  output reg [W-1:0] feed_sample_out,
  output reg feed_valid_out,
  output reg [W-1:0] dsp_sample_out,
  output reg dsp_valid_out
);
  reg [W-1:0] held;
  reg held_full;
  reg [W-1:0] next_sel;
  reg next_valid;
  // serial input either straight through or released on the frame tick
  always @* begin
    if (source_sel_in) begin
      next_sel = spdif_sample_in;
      next_valid = spdif_valid_in;
    end else if (double_buf_en_in) begin
      next_sel = held;
      next_valid = frame_tick_in & held_full;
    end else begin
      next_sel = serial_sample_in;
      next_valid = serial_valid_in;
    end
  end
  // holding register, a new sample wins over the release
  always @(posedge clk_in) begin
    if (reset_in) begin
      held <= {W{1'b0}};
      held_full <= 1'b0;
      feed_sample_out <= {W{1'b0}};
      feed_valid_out <= 1'b0;
      dsp_sample_out <= {W{1'b0}};
      dsp_valid_out <= 1'b0;
    end else begin
      if (serial_valid_in) begin
        held <= serial_sample_in;
        held_full <= 1'b1;
      end else if (frame_tick_in) held_full <= 1'b0;
      feed_sample_out <= next_sel;
      feed_valid_out <= next_valid & ~bypass_in;
      dsp_sample_out <= bypass_in ? next_sel : resampled_in;
      dsp_valid_out <= bypass_in ? next_valid : resampled_valid_in;
    end
  end
endmodule // input_sample_path
`default_nettype wire

// file: rtl/audio_config_register_a.v
// configuration register a with the datapath controls it steers
//
// Function
// - reserved bits masked on read only with compliance bit 0 clear
// - bit 1 enables serial input double buffering
// - gain bits pick 1x/2x/3x and compression
// - bit 4 resets amplifier; bit 5 zero detect
// - bit 6 picks amplifier truth table
// - bit 8 low or test mode bypasses pll
// - bit 9 picks master clock out rate
// - bit 10 picks serial or spdif input
// - bit 11 picks spdif analog or digital
// - threshold bits set anti-alias engage band
// - bit 14 sends ratio value to channels
// - bit 15 bypasses the sample rate converter
// - above full scale clips without compression
// - compression attacks above near-full-scale threshold
// - quiet hold then release raises gain
// - nine constants shape attack and release
`timescale 1ns/10ps
`default_nettype none
`include "config_reg_a_defs.vh"
module audio_config_register_a #(
  parameter W = 24,
  parameter CNT_W = 12
) (
  input wire ref_clk_in,
  input wire reset_in,
  input wire test_mode_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [6:0] reg_addr_in,
  input wire [15:0] reg_wdata_in,
  input wire [W-1:0] serial_sample_in,
  input wire serial_valid_in,
  input wire [W-1:0] spdif_sample_in,
  input wire spdif_valid_in,
  input wire [W-1:0] resampled_in,
  input wire resampled_valid_in,
  input wire frame_tick_in,
  input wire [W-1:0] gain_stage_sample_in,
  input wire gain_stage_valid_in,
  input wire [W-1:0] ratio_value_in,
  output reg [15:0] reg_rdata_out,
  output reg reg_rvalid_out,
  output wire [W-1:0] resampler_feed_out,
  output wire resampler_feed_valid_out,
  output wire [W-1:0] dsp_sample_out,
  output wire dsp_valid_out,
  output reg [W-1:0] channel_sample_out,
  output reg channel_valid_out,
  output reg input_double_buffer_en_out,
  output reg [1:0] amp_gain_sel_out,
  output reg amp_stage_reset_out,
  output reg amp_zero_detect_en_out,
  output reg zero_detected_out,
  output reg amp_truth_table_sel_out,
  output reg pll_mult_sel_out,
  output reg pll_route_out,
  output reg master_clk_out_rate_sel_out,
  output reg input_source_sel_out,
  output reg spdif_digital_mode_out,
  output reg antialias_engage_out,
  output reg ratio_debug_en_out,
  output reg resampler_bypass_out
);
  // measurement states
  localparam [1:0] MEAS_IDLE = 2'b00;
  localparam [1:0] MEAS_RUN = 2'b01;
  localparam [1:0] MEAS_STALE = 2'b10;
  // band edges in ref clock cycles, cut to the counter width where used
  localparam [31:0] BAND1_ON = `AA_BAND1_ON_CYC;
  localparam [31:0] BAND1_OFF = `AA_BAND1_OFF_CYC;
  localparam [31:0] BAND2_ON = `AA_BAND2_ON_CYC;
  localparam [31:0] BAND2_OFF = `AA_BAND2_OFF_CYC;

  reg [15:0] config_register_a;
  reg tm_s1;
  reg tm_s2;
  reg tm_s3;
  reg test_mode;
  reg [1:0] meas_state;
  reg [1:0] next_meas_state;
  reg [CNT_W-1:0] period_cnt;
  reg [CNT_W-1:0] on_cyc;
  reg [CNT_W-1:0] off_cyc;
  reg [11:0] zero_run;
  wire hit = reg_addr_in == `CFG_A_OFFSET;
  wire [W-1:0] lim_sample;
  wire lim_valid;
  wire lim_reset = reset_in | config_register_a[`FLD_AMP_RESET];
  wire rate_strobe = config_register_a[`FLD_INPUT_SEL] ? spdif_valid_in : serial_valid_in;
  wire [1:0] thr = {config_register_a[`FLD_AA_THR_HI], config_register_a[`FLD_AA_THR_LO]};
  wire cnt_full = &period_cnt;
  wire [15:0] read_image = config_register_a[`FLD_FULL_COMPLIANCE] ? config_register_a :
    (config_register_a & ~`CFG_A_RESERVED_MASK);

  // register write, all sixteen bits at once
  always @(posedge ref_clk_in) begin
    if (reset_in) config_register_a <= `CFG_A_RESET;
    else if (reg_wr_in && hit) config_register_a <= reg_wdata_in;
  end

  // register read, answered one cycle after the request
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      reg_rdata_out <= 16'h0000;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) reg_rdata_out <= hit ? read_image : 16'h0000;
    end
  end

  // test mode pin synchroniser, change taken when stages two and three agree
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      tm_s1 <= 1'b0;
      tm_s2 <= 1'b0;
      tm_s3 <= 1'b0;
      test_mode <= 1'b0;
    end else begin
      tm_s1 <= test_mode_in;
      tm_s2 <= tm_s1;
      tm_s3 <= tm_s2;
      if (tm_s2 == tm_s3) test_mode <= tm_s3;
    end
  end

  // configuration fields presented as registered control outputs
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      input_double_buffer_en_out <= 1'b0;
      amp_gain_sel_out <= 2'b00;
      amp_stage_reset_out <= 1'b1;
      amp_zero_detect_en_out <= 1'b1;
      amp_truth_table_sel_out <= 1'b1;
      pll_mult_sel_out <= 1'b0;
      pll_route_out <= 1'b1;
      master_clk_out_rate_sel_out <= 1'b0;
      input_source_sel_out <= 1'b0;
      spdif_digital_mode_out <= 1'b0;
      ratio_debug_en_out <= 1'b0;
      resampler_bypass_out <= 1'b0;
    end else begin
      input_double_buffer_en_out <= config_register_a[`FLD_DOUBLE_BUFFER];
      amp_gain_sel_out <= {config_register_a[`FLD_GAIN_HI],
        config_register_a[`FLD_GAIN_LO]};
      amp_stage_reset_out <= config_register_a[`FLD_AMP_RESET];
      amp_zero_detect_en_out <= config_register_a[`FLD_ZERO_DETECT];
      amp_truth_table_sel_out <= config_register_a[`FLD_TRUTH_TABLE];
      pll_mult_sel_out <= config_register_a[`FLD_PLL_MULT];
      pll_route_out <= config_register_a[`FLD_PLL_ROUTE] & ~test_mode;
      master_clk_out_rate_sel_out <= config_register_a[`FLD_MCLK_RATE];
      input_source_sel_out <= config_register_a[`FLD_INPUT_SEL];
      spdif_digital_mode_out <= config_register_a[`FLD_SPDIF_MODE];
      ratio_debug_en_out <= config_register_a[`FLD_RATIO_DEBUG];
      resampler_bypass_out <= config_register_a[`FLD_RESAMPLER_BYPASS];
    end
  end

  // band edges for the selected anti-alias threshold
  always @* begin
    case (thr)
      2'b10: begin
        on_cyc = BAND1_ON[CNT_W-1:0];
        off_cyc = BAND1_OFF[CNT_W-1:0];
      end
      2'b01: begin
        on_cyc = BAND2_ON[CNT_W-1:0];
        off_cyc = BAND2_OFF[CNT_W-1:0];
      end
      default: begin
        on_cyc = {CNT_W{1'b0}};
        off_cyc = {CNT_W{1'b0}};
      end
    endcase
  end

  // input rate measurement sequencing
  always @* begin
    case (meas_state)
      MEAS_IDLE: next_meas_state = rate_strobe ? MEAS_RUN : MEAS_IDLE;
      MEAS_RUN: next_meas_state = (cnt_full && !rate_strobe) ? MEAS_STALE : MEAS_RUN;
      MEAS_STALE: next_meas_state = rate_strobe ? MEAS_RUN : MEAS_STALE;
      default: next_meas_state = MEAS_IDLE;
    endcase
  end

  // period count between input strobes and engage decision with hysteresis
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      meas_state <= MEAS_IDLE;
      period_cnt <= {CNT_W{1'b0}};
      antialias_engage_out <= 1'b0;
    end else begin
      meas_state <= next_meas_state;
      if (rate_strobe) period_cnt <= {CNT_W{1'b0}};
      else if (!cnt_full) period_cnt <= period_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      if (thr == 2'b11) antialias_engage_out <= 1'b1;
      else if (thr == 2'b00) antialias_engage_out <= 1'b0;
      else if (meas_state == MEAS_STALE) antialias_engage_out <= 1'b0;
      else if (rate_strobe && meas_state == MEAS_RUN) begin
        if (period_cnt <= on_cyc) antialias_engage_out <= 1'b1;
        else if (period_cnt >= off_cyc) antialias_engage_out <= 1'b0;
      end
    end
  end

  // zero detect over a run of silent samples at the gain stage input
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      zero_run <= 12'h000;
      zero_detected_out <= 1'b0;
    end else begin
      if (!config_register_a[`FLD_ZERO_DETECT]) zero_run <= 12'h000;
      else if (gain_stage_valid_in) begin
        if (gain_stage_sample_in != {W{1'b0}}) zero_run <= 12'h000;
        else if (zero_run != `ZERO_RUN_SAMPLES) zero_run <= zero_run + 12'h001;
      end
      zero_detected_out <= config_register_a[`FLD_ZERO_DETECT] &&
        zero_run == `ZERO_RUN_SAMPLES;
    end
  end

  // source selection, double buffering and resampler bypass
  input_sample_path #(
    .W(W)
  ) u_path (
    .clk_in(ref_clk_in),
    .reset_in(reset_in),
    .source_sel_in(config_register_a[`FLD_INPUT_SEL]),
    .double_buf_en_in(config_register_a[`FLD_DOUBLE_BUFFER]),
    .bypass_in(config_register_a[`FLD_RESAMPLER_BYPASS]),
    .serial_sample_in(serial_sample_in),
    .serial_valid_in(serial_valid_in),
    .spdif_sample_in(spdif_sample_in),
    .spdif_valid_in(spdif_valid_in),
    .resampled_in(resampled_in),
    .resampled_valid_in(resampled_valid_in),
    .frame_tick_in(frame_tick_in),
    .feed_sample_out(resampler_feed_out),
    .feed_valid_out(resampler_feed_valid_out),
    .dsp_sample_out(dsp_sample_out),
    .dsp_valid_out(dsp_valid_out)
  );

  // gain, clipping and compression, held in reset by the amplifier reset bit
  output_limiter #(
    .W(W)
  ) u_limiter (
    .clk_in(ref_clk_in),
    .reset_in(lim_reset),
    .gain_sel_in({config_register_a[`FLD_GAIN_HI], config_register_a[`FLD_GAIN_LO]}),
    .sample_in(gain_stage_sample_in),
    .valid_in(gain_stage_valid_in),
    .sample_out(lim_sample),
    .valid_out(lim_valid)
  );

  // channel output carries either audio or the rate ratio value
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      channel_sample_out <= {W{1'b0}};
      channel_valid_out <= 1'b0;
    end else begin
      channel_valid_out <= lim_valid;
      if (lim_valid)
        channel_sample_out <= config_register_a[`FLD_RATIO_DEBUG] ?
          ratio_value_in : lim_sample;
    end
  end
endmodule // audio_config_register_a
`default_nettype wire

// file: tb/config_reg_a_properties.sv
// port checker for configuration register a
`timescale 1ns/10ps
`default_nettype none
module config_reg_a_properties (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic test_mode_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [6:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire logic resampler_feed_valid_out,
  input wire logic [1:0] amp_gain_sel_out,
  input wire logic amp_stage_reset_out,
  input wire logic pll_route_out,
  input wire logic resampler_bypass_out,
  input wire logic ratio_debug_en_out,
  input wire logic input_source_sel_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  // requests aimed at the mapped register
  wire logic wr_hit = reg_wr_in && (reg_addr_in == 7'h5A);
  sequence write_hit;
    wr_hit;
  endsequence
  sequence clean_read;
    reg_rd_in && !reg_wr_in && (reg_addr_in == 7'h5A);
  endsequence
  chk_read_answer: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("no read answer");
  chk_rvalid_single: assert property (!reg_rd_in |=> !reg_rvalid_out)
    else $error("read answer without read");
  chk_unmapped_zero: assert property (reg_rd_in && reg_addr_in != 7'h5A |=> reg_rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  chk_read_back: assert property (write_hit ##1 clean_read |=> reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("read back differs");
  chk_gain_copy: assert property (write_hit |-> ##2 amp_gain_sel_out == $past(reg_wdata_in[3:2], 2))
    else $error("gain field not taken");
  chk_amp_reset: assert property (write_hit |-> ##2 amp_stage_reset_out == $past(reg_wdata_in[4], 2))
    else $error("amp reset not taken");
  chk_fields_copy: assert property (write_hit |-> ##2 {resampler_bypass_out,
    ratio_debug_en_out, input_source_sel_out} == $past({reg_wdata_in[15:14], reg_wdata_in[10]}, 2))
    else $error("mode fields not taken");
  chk_write_ignored: assert property (!wr_hit |-> ##2 $stable(amp_gain_sel_out) && $stable(resampler_bypass_out))
    else $error("register changed without write");
  chk_test_force: assert property (test_mode_in [*6] |-> !pll_route_out)
    else $error("pll not bypassed in test mode");
  chk_bypass_feed: assert property (resampler_bypass_out |-> !resampler_feed_valid_out)
    else $error("converter fed in bypass");
endmodule // config_reg_a_properties
bind audio_config_register_a config_reg_a_properties config_reg_a_properties_i (
  .ref_clk_in(ref_clk_in), .reset_in(reset_in), .test_mode_in(test_mode_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
  .resampler_feed_valid_out(resampler_feed_valid_out), .amp_gain_sel_out(amp_gain_sel_out),
  .amp_stage_reset_out(amp_stage_reset_out), .pll_route_out(pll_route_out),
  .resampler_bypass_out(resampler_bypass_out), .ratio_debug_en_out(ratio_debug_en_out),
  .input_source_sel_out(input_source_sel_out));
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for configuration register a
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic ref_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic test_mode_in = 1'b0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [6:0] reg_addr_in = 7'h00;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic [23:0] serial_sample_in = 24'h000000;
  logic [23:0] spdif_sample_in = 24'h000000;
  logic [23:0] resampled_in = 24'h000000;
  logic [23:0] gain_stage_sample_in = 24'h000000;
  logic [23:0] ratio_value_in = 24'h000000;
  logic serial_valid_in = 1'b0;
  logic spdif_valid_in = 1'b0;
  logic resampled_valid_in = 1'b0;
  logic frame_tick_in = 1'b0;
  logic gain_stage_valid_in = 1'b0;
  wire [15:0] reg_rdata_out;
  wire [23:0] resampler_feed_out, dsp_sample_out, channel_sample_out;
  wire [1:0] amp_gain_sel_out;
  wire reg_rvalid_out, resampler_feed_valid_out, dsp_valid_out, channel_valid_out;
  wire input_double_buffer_en_out, amp_stage_reset_out, amp_zero_detect_en_out;
  wire zero_detected_out, amp_truth_table_sel_out, pll_mult_sel_out, pll_route_out;
  wire master_clk_out_rate_sel_out, input_source_sel_out, spdif_digital_mode_out;
  wire antialias_engage_out, ratio_debug_en_out, resampler_bypass_out;
  integer seed = 16345;
  integer bad_count = 0;
  integer num_checks = 0;
  integer cycles = 0;
  logic [15:0] v, d;
  logic [23:0] s, e;
  logic [6:0] a;
  logic [1:0] code;
  audio_config_register_a audio_config_register_a_i (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .test_mode_in(test_mode_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .serial_sample_in(serial_sample_in),
    .serial_valid_in(serial_valid_in), .spdif_sample_in(spdif_sample_in),
    .spdif_valid_in(spdif_valid_in), .resampled_in(resampled_in),
    .resampled_valid_in(resampled_valid_in), .frame_tick_in(frame_tick_in),
    .gain_stage_sample_in(gain_stage_sample_in), .gain_stage_valid_in(gain_stage_valid_in),
    .ratio_value_in(ratio_value_in), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out), .resampler_feed_out(resampler_feed_out),
    .resampler_feed_valid_out(resampler_feed_valid_out), .dsp_sample_out(dsp_sample_out),
    .dsp_valid_out(dsp_valid_out), .channel_sample_out(channel_sample_out),
    .channel_valid_out(channel_valid_out), .input_double_buffer_en_out(input_double_buffer_en_out),
    .amp_gain_sel_out(amp_gain_sel_out), .amp_stage_reset_out(amp_stage_reset_out),
    .amp_zero_detect_en_out(amp_zero_detect_en_out), .zero_detected_out(zero_detected_out),
    .amp_truth_table_sel_out(amp_truth_table_sel_out), .pll_mult_sel_out(pll_mult_sel_out),
    .pll_route_out(pll_route_out), .master_clk_out_rate_sel_out(master_clk_out_rate_sel_out),
    .input_source_sel_out(input_source_sel_out), .spdif_digital_mode_out(spdif_digital_mode_out),
    .antialias_engage_out(antialias_engage_out), .ratio_debug_en_out(ratio_debug_en_out),
    .resampler_bypass_out(resampler_bypass_out));
  // clock and hang guard
  always #12.5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 9000) begin
      bad_count = bad_count + 1;
      test_done();
    end
  end
  // control outputs packed as register image, threshold and compliance bits blank
  function automatic logic [15:0] ctl_img();
    return {resampler_bypass_out, ratio_debug_en_out, 2'b00, spdif_digital_mode_out,
      input_source_sel_out, master_clk_out_rate_sel_out, pll_route_out, pll_mult_sel_out,
      amp_truth_table_sel_out, amp_zero_detect_en_out, amp_stage_reset_out,
      amp_gain_sel_out, input_double_buffer_en_out, 1'b0};
  endfunction
  // gain with clipping at full scale, compression idle for small samples
  function automatic logic [23:0] gain_exp(input logic [1:0] c, input logic [23:0] x);
    logic signed [25:0] p;
    p = {{2{x[23]}}, x};
    if (c != 2'b00) p = p <<< 1;
    if (c == 2'b11) p = p + {{2{x[23]}}, x};
    if (p > 26'sh07FFFFF) p = 26'sh07FFFFF;
    if (p < -26'sh0800000) p = -26'sh0800000;
    return p[23:0];
  endfunction
  // serial strobe followed by a quiet gap, n cycles in all
  task automatic gap(input int n);
    serial_valid_in = 1'b1;
    @(negedge ref_clk_in);
    serial_valid_in = 1'b0;
    repeat (n - 1) @(negedge ref_clk_in);
  endtask
  task automatic chk_reg(input string n, input logic [15:0] x, input logic [15:0] g);
    num_checks++;
    if (g !== x) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic chk_smp(input string n, input logic [23:0] x, input logic [23:0] g);
    num_checks++;
    if (g !== x) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wr(input logic [6:0] ad, input logic [15:0] dat);
    reg_wr_in = 1'b1;
    reg_addr_in = ad;
    reg_wdata_in = dat;
    @(negedge ref_clk_in);
    reg_wr_in = 1'b0;
  endtask
  task automatic rd(input logic [6:0] ad, output logic [15:0] dat);
    reg_rd_in = 1'b1;
    reg_addr_in = ad;
    @(negedge ref_clk_in);
    reg_rd_in = 1'b0;
    chk_reg("rvalid", 16'h0001, {15'h0000, reg_rvalid_out});
    dat = reg_rdata_out;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge ref_clk_in);
    reset_in = 1'b0;
    chk_reg("reset_ctl", 16'h0170, ctl_img());
    rd(7'h5A, d);
    chk_reg("reset_val", 16'h1170, d);
    $display("test reset done");
    // corner images, then random ones, each read straight after the write
    for (int i = 0; i < 16; i++) begin
      case (i)
        0: v = 16'hFFFF;
        1: v = 16'h0000;
        2: v = 16'h0004;
        3: v = 16'h0008;
        4: v = 16'h000C;
        default: v = $random(seed);
      endcase
      wr(7'h5A, v);
      rd(7'h5A, d);
      chk_reg("readback", v, d);
      chk_reg("ctl", v & 16'hCFFE, ctl_img());
      a = $random(seed);
      if (a == 7'h5A) a = 7'h5B;
      wr(a, ~v);
      rd(7'h5A, d);
      chk_reg("ignored_wr", v, d);
      @(negedge ref_clk_in);
      rd(a, d);
      chk_reg("unmapped", 16'h0000, d);
    end
    $display("test register done");
    wr(7'h5A, 16'h0100);
    test_mode_in = 1'b1;
    repeat (6) @(negedge ref_clk_in);
    chk_reg("route_test", 16'h0000, {15'h0000, pll_route_out});
    test_mode_in = 1'b0;
    repeat (6) @(negedge ref_clk_in);
    chk_reg("route_norm", 16'h0001, {15'h0000, pll_route_out});
    $display("test pll done");
    // source select against bypass, every pairing
    for (int m = 0; m < 4; m++) begin
      wr(7'h5A, {m[1], 4'h0, m[0], 10'h000});
      s = $random(seed);
      serial_sample_in = s;
      spdif_sample_in = ~s;
      resampled_in = s ^ 24'h5A5A5A;
      serial_valid_in = 1'b1;
      spdif_valid_in = 1'b1;
      resampled_valid_in = 1'b1;
      @(negedge ref_clk_in);
      serial_valid_in = 1'b0;
      spdif_valid_in = 1'b0;
      resampled_valid_in = 1'b0;
      e = m[0] ? ~s : s;
      chk_smp("dsp", m[1] ? e : s ^ 24'h5A5A5A, dsp_sample_out);
      chk_reg("dsp_valid", 16'h0001, {15'h0000, dsp_valid_out});
      chk_reg("feed_valid", {15'h0000, !m[1]}, {15'h0000, resampler_feed_valid_out});
      if (!m[1]) chk_smp("feed", e, resampler_feed_out);
    end
    // double buffered serial sample waits for the frame tick
    wr(7'h5A, 16'h0002);
    serial_sample_in = s;
    serial_valid_in = 1'b1;
    @(negedge ref_clk_in);
    serial_valid_in = 1'b0;
    chk_reg("dbuf_hold", 16'h0000, {15'h0000, resampler_feed_valid_out});
    frame_tick_in = 1'b1;
    @(negedge ref_clk_in);
    frame_tick_in = 1'b0;
    chk_smp("dbuf_out", s, resampler_feed_out);
    $display("test input done");
    // gain cases: 1x pass, 2x clip both ways, debug ratio, 3x and 2x compressed
    for (int i = 0; i < 7; i++) begin
      code = (i == 5) ? 2'b11 : (i == 6) ? 2'b01 : (i == 0 || i == 4) ? 2'b00 : 2'b10;
      s = (i == 1) ? 24'h600000 : (i == 2) ? 24'hA00000 : (i == 3 || i > 4) ? 24'h123456 :
        24'h0FFFFF & $random(seed);
      wr(7'h5A, {1'b0, i == 4, 10'h000, code, 2'b00});
      ratio_value_in = $random(seed);
      gain_stage_sample_in = s;
      gain_stage_valid_in = 1'b1;
      @(negedge ref_clk_in);
      gain_stage_valid_in = 1'b0;
      @(negedge ref_clk_in);
      chk_reg("ch_valid", 16'h0001, {15'h0000, channel_valid_out});
      chk_smp("channel", (i == 4) ? ratio_value_in : gain_exp(code, s), channel_sample_out);
    end
    $display("test channel done");
    // anti-alias band 1 by strobe spacing, always on, then off during zero detect
    wr(7'h5A, 16'h2000);
    gap(600);
    gap(600);
    chk_reg("aa_band", 16'h0001, {15'h0000, antialias_engage_out});
    gap(700);
    gap(10);
    chk_reg("aa_drop", 16'h0000, {15'h0000, antialias_engage_out});
    wr(7'h5A, 16'h3000);
    @(negedge ref_clk_in);
    chk_reg("aa_on", 16'h0001, {15'h0000, antialias_engage_out});
    wr(7'h5A, 16'h0020);
    gain_stage_sample_in = 24'h000000;
    gain_stage_valid_in = 1'b1;
    repeat (2048) @(negedge ref_clk_in);
    chk_reg("zero_early", 16'h0000, {15'h0000, zero_detected_out});
    @(negedge ref_clk_in);
    gain_stage_valid_in = 1'b0;
    chk_reg("zero_det", 16'h0001, {15'h0000, zero_detected_out});
    chk_reg("aa_off", 16'h0000, {15'h0000, antialias_engage_out});
    $display("test detect done");
    test_done();
  end
endmodule // tb_top
`default_nettype wire
